//--- design/spfs_sequencer.v
`timescale 1ns/10ps
`include "spfs_map.vh"
module spfs_sequencer #(
	parameter WADDR = 23,
	parameter LAST_PAGE = 8'h15
) (
	input  wire        mclk,
	input  wire        nrst,
	input  wire        ctl_wr,
	input  wire [15:0] ctl_wdata,
	input  wire        key_wr,
	input  wire [7:0]  key_wdata,
	input  wire [WADDR-1:0] tgt_addr,
	input  wire [23:0] tgt_data,
	output reg  [15:0] ctl_rdata,
	output reg         cpu_stall,
	output reg         arr_erase,
	output reg         arr_prog,
	output reg  [WADDR-1:0] arr_addr,
	output reg  [23:0] arr_wdata,
	output reg         cfg_clear,
	output reg         op_done
);
	localparam ST_IDLE   = 2'b00;
	localparam ST_BUSY   = 2'b01;
	localparam ST_DONE   = 2'b10;
	localparam KEY_NONE  = 2'b00;
	localparam KEY_HALF  = 2'b01;
	localparam KEY_ARMED = 2'b11;

	// bits below the page number, from the row geometry
	function integer log2_of;
		input integer v;
		integer       i;
		begin
			log2_of = 0;
			for (i = v; i > 1; i = i / 2)
				log2_of = log2_of + 1;
		end
	endfunction

	localparam PAGE_WORDS = `SPFS_PAGE_ROWS * `SPFS_ROW_WORDS;
	localparam PG_SHIFT   = log2_of(PAGE_WORDS);
	localparam OSC_LAST   = `SPFS_OSC_CYCLES - 1;

	reg [1:0]       state_r;
	reg [1:0]       state_nxt;
	reg [15:0]      ctl_r;
	reg [15:0]      ctl_nxt;
	reg [1:0]       key_r;
	reg [1:0]       key_nxt;
	reg [8:0]       osc_cnt_r;
	reg [8:0]       osc_cnt_nxt;
	reg             stall_nxt;
	reg             erase_nxt;
	reg             prog_nxt;
	reg [WADDR-1:0] addr_nxt;
	reg [23:0]      wdata_nxt;
	reg             cfg_nxt;
	reg             done_nxt;
	wire            rc_tick;
	wire            rc_run;
	wire [3:0]      op_sel;
	wire            op_ok;
	wire            start_req;

	// operation field of a control word
	function [3:0] op_field;
		input [15:0] w;
		op_field = w[`SPFS_CTL_OP_MSB:`SPFS_CTL_OP_LSB];
	endfunction

	function op_is_erase;
		input [3:0] op;
		op_is_erase = (op == `SPFS_OP_PAGE_ERASE);
	endfunction

	function op_is_prog;
		input [3:0] op;
		op_is_prog = (op == `SPFS_OP_WORD_PROG);
	endfunction

	// word address of the first word of the page holding a
	function [WADDR-1:0] page_base;
		input [WADDR-1:0] a;
		page_base = {a[WADDR-1:PG_SHIFT], {PG_SHIFT{1'b0}}};
	endfunction

	// wiping the last page also drops the configuration words
	function last_page;
		input [WADDR-1:0] a;
		last_page = (a[WADDR-1:PG_SHIFT] == LAST_PAGE);
	endfunction

	assign op_sel    = op_field(ctl_wdata);
	assign op_ok     = op_is_erase(op_sel) || op_is_prog(op_sel);
	assign rc_run    = (state_r == ST_BUSY);
	// a refused start only stores the other control bits
	assign start_req = ctl_wr && ctl_wdata[`SPFS_CTL_START_BIT] && key_r == KEY_ARMED && op_ok;

	spfs_rc_tick u_tick (
		.mclk (mclk),
		.nrst (nrst),
		.run  (rc_run),
		.tick (rc_tick)
	);

	// only the arming state is kept, so no key value can ever be read back
	always @* begin
		key_nxt = key_r;
		if (key_wr) begin
			if (key_wdata == `SPFS_KEY_FIRST)
				key_nxt = KEY_HALF;
			else if (key_wdata == `SPFS_KEY_SECOND && key_r == KEY_HALF)
				key_nxt = KEY_ARMED;
			else
				key_nxt = KEY_NONE;
		end else if (ctl_wr) begin
			// a control write consumes the arming, used or not, unless a key write comes in the same cycle
			key_nxt = KEY_NONE;
		end
	end

	always @* begin
		state_nxt   = state_r;
		ctl_nxt     = ctl_r;
		osc_cnt_nxt = osc_cnt_r;
		stall_nxt   = cpu_stall;
		erase_nxt   = arr_erase;
		prog_nxt    = arr_prog;
		addr_nxt    = arr_addr;
		wdata_nxt   = arr_wdata;
		cfg_nxt     = cfg_clear;
		done_nxt    = 1'b0;
		case (state_r)
		ST_IDLE: begin
			if (ctl_wr) begin
				ctl_nxt = ctl_wdata & ~(16'h0001 << `SPFS_CTL_START_BIT);
			end
			if (start_req) begin
				ctl_nxt[`SPFS_CTL_START_BIT] = 1'b1;
				state_nxt   = ST_BUSY;
				stall_nxt   = 1'b1;
				osc_cnt_nxt = 9'h000;
				if (op_is_erase(op_sel)) begin
					erase_nxt = 1'b1;
					addr_nxt  = page_base(tgt_addr);
					cfg_nxt   = last_page(tgt_addr);
				end else begin
					prog_nxt  = 1'b1;
					addr_nxt  = tgt_addr;
					wdata_nxt = tgt_data;
				end
			end
		end
		ST_BUSY: begin
			// writes while busy leave the control word alone and only reach the key tracker: the cpu is stalled anyway
			if (rc_tick) begin
				if ({23'h000000, osc_cnt_r} == OSC_LAST) begin
					state_nxt = ST_DONE;
					erase_nxt = 1'b0;
					prog_nxt  = 1'b0;
					cfg_nxt   = 1'b0;
				end else begin
					osc_cnt_nxt = osc_cnt_r + 9'h001;
				end
			end
		end
		ST_DONE: begin
			ctl_nxt[`SPFS_CTL_START_BIT] = 1'b0;
			stall_nxt = 1'b0;
			done_nxt  = 1'b1;
			state_nxt = ST_IDLE;
		end
		default: begin
			state_nxt = ST_IDLE;
		end
		endcase
	end

	always @(posedge mclk) begin
		if (!nrst) begin
			key_r <= KEY_NONE;
		end else begin
			key_r <= key_nxt;
		end
	end

	always @(posedge mclk) begin
		if (!nrst) begin
			state_r   <= ST_IDLE;
			ctl_r     <= `SPFS_CTL_RESET;
			osc_cnt_r <= 9'h000;
			cpu_stall <= 1'b0;
			arr_erase <= 1'b0;
			arr_prog  <= 1'b0;
			arr_addr  <= {WADDR{1'b0}};
			arr_wdata <= 24'h000000;
			cfg_clear <= 1'b0;
			op_done   <= 1'b0;
			ctl_rdata <= `SPFS_CTL_RESET;
		end else begin
			state_r   <= state_nxt;
			ctl_r     <= ctl_nxt;
			osc_cnt_r <= osc_cnt_nxt;
			cpu_stall <= stall_nxt;
			arr_erase <= erase_nxt;
			arr_prog  <= prog_nxt;
			arr_addr  <= addr_nxt;
			arr_wdata <= wdata_nxt;
			cfg_clear <= cfg_nxt;
			op_done   <= done_nxt;
			ctl_rdata <= ctl_r;
		end
	end
endmodule

//--- include/spfs_map.vh
`ifndef SPFS_MAP_VH
`define SPFS_MAP_VH
// array geometry
`define SPFS_ROW_WORDS        64
`define SPFS_ROW_BYTES        192
`define SPFS_PAGE_ROWS        8
`define SPFS_PAGE_WORDS       512
`define SPFS_PAGE_BYTES       1536
`define SPFS_WORD_BITS        24
// control register fields
`define SPFS_CTL_START_BIT    15
`define SPFS_CTL_ERASE_BIT    6
`define SPFS_CTL_OP_LSB       0
`define SPFS_CTL_OP_MSB       3
`define SPFS_CTL_RESET        16'h0000
// operation codes in the op field
`define SPFS_OP_WORD_PROG     4'h3
`define SPFS_OP_PAGE_ERASE    4'h2
// unlock key values
`define SPFS_KEY_FIRST        8'h55
`define SPFS_KEY_SECOND       8'hAA
// timing: 355 oscillator cycles at 7.37 MHz, i.e. 7370 kHz
`define SPFS_OSC_CYCLES       355
`define SPFS_OSC_KHZ          7370
`define SPFS_MCLK_KHZ         20000
`define SPFS_RC_DIV           ((`SPFS_MCLK_KHZ + `SPFS_OSC_KHZ - 1) / `SPFS_OSC_KHZ)
`endif

//--- design/spfs_rc_tick.v
`timescale 1ns/10ps
`include "spfs_map.vh"
// stand-in for the internal fast rc oscillator: one-cycle enable every SPFS_RC_DIV mclk cycles, at most its rate
module spfs_rc_tick #(
	parameter DIV = `SPFS_RC_DIV
) (
	input  wire       mclk,
	input  wire       nrst,
	input  wire       run,
	output reg        tick
);
	reg [7:0] cnt_r;
	always @(posedge mclk) begin
		if (!nrst || !run) begin
			cnt_r <= 8'h00;
			tick  <= 1'b0;
		end else if (cnt_r == DIV[7:0] - 8'h01) begin
			cnt_r <= 8'h00;
			tick  <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 8'h01;
			tick  <= 1'b0;
		end
	end
endmodule

//--- test/spfs_chk_checker.sv
`timescale 1ns/10ps
module spfs_chk #(parameter WADDR = 23, LAST_PAGE = 8'h15) (
	input wire logic mclk, nrst, ctl_wr, key_wr, cpu_stall, arr_erase, arr_prog, cfg_clear, op_done,
	input wire logic [15:0] ctl_wdata, ctl_rdata,
	input wire logic [7:0] key_wdata,
	input wire logic [WADDR-1:0] arr_addr,
	input wire logic [23:0] arr_wdata
);
	logic [11:0] cnt_r;
	// long count kept in a counter, too long to unroll
	always @(posedge mclk) cnt_r <= cpu_stall ? cnt_r + 12'h001 : 12'h000;
	logic half_r, armed_r;
	// arming as software sees it, kept apart from the design's own tracker
	always @(posedge mclk) begin
		if (!nrst) begin
			half_r  <= 1'b0;
			armed_r <= 1'b0;
		end else if (key_wr) begin
			half_r  <= key_wdata == 8'h55;
			armed_r <= half_r && key_wdata == 8'hAA;
		end else if (ctl_wr) begin
			half_r  <= 1'b0;
			armed_r <= 1'b0;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	sequence s_end; op_done ##1 !ctl_rdata[15]; endsequence
	property p_len; $fell(cpu_stall) |-> cnt_r > 12'h41A && cnt_r < 12'h438; endproperty
	a_len: assert property (p_len) else $error("len");
	property p_end; $fell(cpu_stall) |-> s_end; endproperty
	a_end: assert property (p_end) else $error("end");
	property p_busy; arr_prog || arr_erase |-> cpu_stall; endproperty
	a_busy: assert property (p_busy) else $error("stall");
	property p_one; !(arr_prog && arr_erase); endproperty
	a_one: assert property (p_one) else $error("two ops");
	property p_base; arr_erase |-> arr_addr[8:0] == 9'h000; endproperty
	a_base: assert property (p_base) else $error("base");
	property p_cfg; cfg_clear |-> arr_erase && arr_addr[WADDR-1:9] == LAST_PAGE; endproperty
	a_cfg: assert property (p_cfg) else $error("cfg");
	property p_hold; $past(cpu_stall) && cpu_stall |-> $stable(arr_addr) && $stable(arr_wdata); endproperty
	a_hold: assert property (p_hold) else $error("moved");
	property p_go; $rose(cpu_stall) |-> $past(ctl_wr && ctl_wdata[15]); endproperty
	a_go: assert property (p_go) else $error("start");
	property p_key; $rose(cpu_stall) |-> $past(armed_r); endproperty
	a_key: assert property (p_key) else $error("unarmed start");
endmodule
bind spfs_sequencer spfs_chk #(.WADDR(WADDR), .LAST_PAGE(LAST_PAGE)) spfs_chk_inst (
	.mclk      (mclk),
	.nrst      (nrst),
	.ctl_wr    (ctl_wr),
	.key_wr    (key_wr),
	.cpu_stall (cpu_stall),
	.arr_erase (arr_erase),
	.arr_prog  (arr_prog),
	.cfg_clear (cfg_clear),
	.op_done   (op_done),
	.ctl_wdata (ctl_wdata),
	.ctl_rdata (ctl_rdata),
	.key_wdata (key_wdata),
	.arr_addr  (arr_addr),
	.arr_wdata (arr_wdata)
);

//--- test/spfs_mem.sv
`timescale 1ns/10ps
module spfs_mem (
	input wire logic mclk, arr_erase, arr_prog,
	input wire logic [22:0] arr_addr,
	input wire logic [23:0] arr_wdata
);
	logic [23:0] mem [0:16383] = '{default: 24'h000000};
	logic ep_r, pp_r;
	always @(posedge mclk) begin
		ep_r <= arr_erase;
		pp_r <= arr_prog;
		if (arr_erase && !ep_r)
			for (int i = 0; i < 512; i++)
				mem[arr_addr + i] <= 24'hFFFFFF;
		// cells only lose ones: an unerased word keeps its zeros
		if (arr_prog && !pp_r)
			mem[arr_addr] <= mem[arr_addr] & arr_wdata;
	end
endmodule

//--- test/testbench.sv
`timescale 1ns/10ps
module testbench;
	logic mclk = 0, nrst = 0, ctl_wr = 0, key_wr = 0, cf, seen, hung = 0;
	logic [15:0] ctl_wdata = 16'h0000, ctl_rdata;
	logic [7:0] key_wdata = 8'h00;
	logic [22:0] tgt_addr = 23'h000000, arr_addr;
	logic [23:0] tgt_data = 24'h123456, arr_wdata;
	logic cpu_stall, arr_erase, arr_prog, cfg_clear, op_done;
	int failures = 0, checks = 0, n;
	always #25 mclk = !mclk;
	spfs_sequencer spfs_sequencer_inst (
		.mclk      (mclk),
		.nrst      (nrst),
		.ctl_wr    (ctl_wr),
		.ctl_wdata (ctl_wdata),
		.key_wr    (key_wr),
		.key_wdata (key_wdata),
		.tgt_addr  (tgt_addr),
		.tgt_data  (tgt_data),
		.ctl_rdata (ctl_rdata),
		.cpu_stall (cpu_stall),
		.arr_erase (arr_erase),
		.arr_prog  (arr_prog),
		.arr_addr  (arr_addr),
		.arr_wdata (arr_wdata),
		.cfg_clear (cfg_clear),
		.op_done   (op_done)
	);
	spfs_mem spfs_mem_inst (
		.mclk      (mclk),
		.arr_erase (arr_erase),
		.arr_prog  (arr_prog),
		.arr_addr  (arr_addr),
		.arr_wdata (arr_wdata)
	);
	task print_verdict;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input [23:0] s, e);
		checks++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %0t %h %h", $time, s, e);
		end
	endtask
	task wr(input k, input [15:0] w);
		@(negedge mclk);
		{key_wr, ctl_wr, key_wdata, ctl_wdata} = {k, !k, w[7:0], w};
		@(negedge mclk);
		{key_wr, ctl_wr} = 2'b00;
	endtask
	task run(input [15:0] c, input [22:0] a, input [1:0] u, input ok);
		if (!hung) begin
			tgt_addr = a;
			cf = 0;
			seen = 0;
			if (u != 0) begin
				wr(1, 16'h0055);
				wr(1, 16'h00AA);
			end
			// a plain control write in between must disarm
			if (u[1])
				wr(0, 16'h0003);
			wr(0, c);
			// no bus traffic while the start settles and the operation runs
			for (n = 0; n < 1200 && op_done !== 1'b1; n++) begin
				@(negedge mclk);
				cf |= cfg_clear;
				seen |= ctl_rdata[15];
			end
			chk(n > 1050 && n < 1080, ok);
			chk(seen, ok);
			if (ok && n == 1200)
				hung = 1;
			@(negedge mclk);
			chk(ctl_rdata[15], 1'b0);
			chk(ctl_rdata, {1'b0, c[14:0]});
			chk(cpu_stall, 1'b0);
			$display("test ends after %0d cycles", n);
		end
	endtask
	initial begin
		repeat (5) @(negedge mclk);
		nrst = 1;
		run(16'h8002, 23'h000205, 2'b01, 1);
		chk(spfs_mem_inst.mem[12'h200], 24'hFFFFFF);
		chk(spfs_mem_inst.mem[12'h3FF], 24'hFFFFFF);
		chk(spfs_mem_inst.mem[12'h400], 24'h000000);
		chk(cf, 1'b0);
		run(16'h8003, 23'h000207, 2'b01, 1);
		chk(spfs_mem_inst.mem[12'h207], 24'h123456);
		chk(spfs_mem_inst.mem[12'h206], 24'hFFFFFF);
		tgt_data = 24'h000000;
		run(16'h8003, 23'h000208, 2'b00, 0);
		run(16'h8003, 23'h000208, 2'b11, 0);
		run(16'h8005, 23'h000208, 2'b01, 0);
		chk(spfs_mem_inst.mem[12'h208], 24'hFFFFFF);
		run(16'h8002, 23'h002A10, 2'b01, 1);
		chk(cf, 1'b1);
		print_verdict;
	end
endmodule
